// ---- include/idsrc_pkg.sv ----
package idsrc_pkg;

   localparam int NUM_CORES = 2;
   localparam int CORE_W = 1;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int CNT_W = 64;

   typedef logic [CNT_W-1:0] idsrc_count_t;
   typedef logic [3:0] idsrc_state_t;
   typedef logic [CORE_W-1:0] idsrc_core_t;

   // Internal idle state codes, not idle_wait_instruction hints
   localparam idsrc_state_t ST_C4 = 4'h4;
   localparam idsrc_state_t ST_C6 = 4'h6;

   localparam idsrc_count_t CNT_RST = 64'h0;
   localparam idsrc_count_t CNT_ONE = 64'h1;

   // Register indices and the byte offset HI_OFS; byte address is four times the index
   localparam logic [ADDR_W-1:0] PKG_C6_IDX = 16'h03fa;
   localparam logic [ADDR_W-1:0] CORE_C4_IDX = 16'h03fc;
   localparam logic [ADDR_W-1:0] CORE_C6_IDX = 16'h03fd;
   localparam logic [ADDR_W-1:0] CORE_SEL_IDX = 16'h0800;
   localparam logic [ADDR_W-1:0] HI_OFS = 16'h1000;

   localparam logic [ADDR_W-1:0] PKG_LO_ADDR = PKG_C6_IDX << 2;
   localparam logic [ADDR_W-1:0] C4_LO_ADDR = CORE_C4_IDX << 2;
   localparam logic [ADDR_W-1:0] C6_LO_ADDR = CORE_C6_IDX << 2;
   localparam logic [ADDR_W-1:0] PKG_HI_ADDR = PKG_LO_ADDR + HI_OFS;
   localparam logic [ADDR_W-1:0] C4_HI_ADDR = C4_LO_ADDR + HI_OFS;
   localparam logic [ADDR_W-1:0] C6_HI_ADDR = C6_LO_ADDR + HI_OFS;
   localparam logic [ADDR_W-1:0] CORE_SEL_ADDR = CORE_SEL_IDX << 2;

   localparam logic [DATA_W-1:0] RD_ZERO = 32'h0;
   localparam idsrc_core_t CORE_SEL_RST = 1'h0;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } idsrc_apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } idsrc_apb_rsp_t;

   localparam idsrc_apb_rsp_t RSP_RST = '{prdata: 32'h0, pready: 1'b0,
                                         pslverr: 1'b0};

endpackage

// ---- src/idsrc_counter.sv ----
`timescale 1ns/10ps
`default_nettype none

module idsrc_counter (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Count enable
   input wire logic inc,
   // Value
   output var idsrc_pkg::idsrc_count_t count
);

   idsrc_pkg::idsrc_count_t count_r;

   // Wraps silently; 64 bits at any sane tick rate outlives the part
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         count_r <= idsrc_pkg::CNT_RST;
      end else if (inc) begin
         count_r <= count_r + idsrc_pkg::CNT_ONE;
      end
   end

   assign count = count_r;

   property p_cnt_hold;
      @(posedge clk_sys) disable iff (reset)
      !inc |=> count_r == $past(count_r);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold)
      else $error("counter moved without enable");

   property p_cnt_step;
      @(posedge clk_sys) disable iff (reset)
      inc |=> count_r == $past(count_r) + idsrc_pkg::CNT_ONE;
   endproperty
   a_cnt_step: assert property (p_cnt_step)
      else $error("counter did not step by one");

endmodule

`default_nettype wire

// ---- src/idsrc_top.sv ----
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Package counter is 64 bits, bits 63 to 0, read only to software.
// - Package counter counts from reset, only while package is in C6.
// - Each core has a read-only 64-bit counter of time spent in C4.
// - Each core has a second read-only 64-bit counter of time in C6.
// - Counters advance on the P1 rate tick, not the core's actual clock.
// - Qualifying states are internal state codes, not wait hints or ACPI.
module idsrc_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // APB slave
   input wire idsrc_pkg::idsrc_apb_req_t apb_req,
   output var idsrc_pkg::idsrc_apb_rsp_t apb_rsp,
   // Power management state
   input wire logic p1_tick,
   input wire idsrc_pkg::idsrc_state_t pkg_state,
   input wire idsrc_pkg::idsrc_state_t [idsrc_pkg::NUM_CORES-1:0] core_state
);

   idsrc_pkg::idsrc_apb_rsp_t rsp_r;
   idsrc_pkg::idsrc_core_t core_sel_r;
   logic [idsrc_pkg::DATA_W-1:0] snap_r;

   idsrc_pkg::idsrc_count_t pkg_c6_val;
   idsrc_pkg::idsrc_count_t [idsrc_pkg::NUM_CORES-1:0] c4_val;
   idsrc_pkg::idsrc_count_t [idsrc_pkg::NUM_CORES-1:0] c6_val;
   logic pkg_c6_inc;
   logic [idsrc_pkg::NUM_CORES-1:0] c4_inc;
   logic [idsrc_pkg::NUM_CORES-1:0] c6_inc;

   logic acc;
   logic done;
   logic [idsrc_pkg::DATA_W-1:0] rd_data;
   logic rd_err;
   logic snap_load;
   logic [idsrc_pkg::DATA_W-1:0] snap_nxt;
   idsrc_pkg::idsrc_count_t c4_sel;
   idsrc_pkg::idsrc_count_t c6_sel;

   // Package residency
   assign pkg_c6_inc = p1_tick &&
      (pkg_state == idsrc_pkg::ST_C6);

   idsrc_counter u_pkg_c6 (
      .clk_sys(clk_sys),
      .reset(reset),
      .inc(pkg_c6_inc),
      .count(pkg_c6_val)
   );

   // Per-core residency
   genvar gi;
   generate
      for (gi = 0; gi < idsrc_pkg::NUM_CORES; gi++) begin : g_core
         // Tick comes from a fixed-rate source, so frequency changes
         // on the core leave the count scale unchanged
         assign c4_inc[gi] = p1_tick &&
            (core_state[gi] ==
             idsrc_pkg::ST_C4);
         assign c6_inc[gi] = p1_tick &&
            (core_state[gi] == idsrc_pkg::ST_C6);

         idsrc_counter u_c4 (
            .clk_sys(clk_sys),
            .reset(reset),
            .inc(c4_inc[gi]),
            .count(c4_val[gi])
         );

         idsrc_counter u_c6 (
            .clk_sys(clk_sys),
            .reset(reset),
            .inc(c6_inc[gi]),
            .count(c6_val[gi])
         );

         property p_c4_cause;
            @(posedge clk_sys) disable iff (reset)
            (c4_val[gi] != $past(c4_val[gi])) |->
               $past(p1_tick) && $past(core_state[gi]) == idsrc_pkg::ST_C4;
         endproperty
         a_c4_cause: assert property (p_c4_cause)
            else $error("core C4 count moved outside C4");

         property p_c6_cause;
            @(posedge clk_sys) disable iff (reset)
            (c6_val[gi] != $past(c6_val[gi])) |->
               $past(p1_tick) && $past(core_state[gi]) == idsrc_pkg::ST_C6;
         endproperty
         a_c6_cause: assert property (p_c6_cause)
            else $error("core C6 count moved outside C6");

         property p_c6_runs;
            @(posedge clk_sys) disable iff (reset)
            (p1_tick && core_state[gi] == idsrc_pkg::ST_C6) |=>
               c6_val[gi] == $past(c6_val[gi]) + idsrc_pkg::CNT_ONE;
         endproperty
         a_c6_runs: assert property (p_c6_runs)
            else $error("core C6 count missed a tick");

         property p_c4_runs;
            @(posedge clk_sys) disable iff (reset)
            (p1_tick && core_state[gi] == idsrc_pkg::ST_C4) |=>
               c4_val[gi] == $past(c4_val[gi]) + idsrc_pkg::CNT_ONE;
         endproperty
         a_c4_runs: assert property (p_c4_runs)
            else $error("core C4 count missed a tick");

         property p_c4_code_only;
            @(posedge clk_sys) disable iff (reset)
            core_state[gi] == idsrc_pkg::ST_C4 |=>
               c6_val[gi] == $past(c6_val[gi]);
         endproperty
         a_c4_code_only: assert property (p_c4_code_only)
            else $error("core C6 count moved on C4 code");
      end
   endgenerate

   assign c4_sel = c4_val[core_sel_r];
   assign c6_sel = c6_val[core_sel_r];

   // First access cycle answers next cycle; one wait state always
   assign acc = apb_req.psel && apb_req.penable && !rsp_r.pready;
   assign done = apb_req.psel && apb_req.penable && rsp_r.pready;

   // Low read latches the high half so a 64-bit read is coherent
   always_comb begin
      rd_data = idsrc_pkg::RD_ZERO;
      rd_err = 1'b0;
      snap_load = 1'b0;
      snap_nxt = snap_r;
      case (apb_req.paddr)
         idsrc_pkg::PKG_LO_ADDR: begin
            rd_data = pkg_c6_val[idsrc_pkg::DATA_W-1:0];
            rd_err = apb_req.pwrite;
            snap_load = !apb_req.pwrite;
            snap_nxt = pkg_c6_val[idsrc_pkg::CNT_W-1:idsrc_pkg::DATA_W];
         end
         idsrc_pkg::C4_LO_ADDR: begin
            rd_data = c4_sel[idsrc_pkg::DATA_W-1:0];
            rd_err = apb_req.pwrite;
            snap_load = !apb_req.pwrite;
            snap_nxt = c4_sel[idsrc_pkg::CNT_W-1:idsrc_pkg::DATA_W];
         end
         idsrc_pkg::C6_LO_ADDR: begin
            rd_data = c6_sel[idsrc_pkg::DATA_W-1:0];
            rd_err = apb_req.pwrite;
            snap_load = !apb_req.pwrite;
            snap_nxt = c6_sel[idsrc_pkg::CNT_W-1:idsrc_pkg::DATA_W];
         end
         idsrc_pkg::PKG_HI_ADDR,
         idsrc_pkg::C4_HI_ADDR,
         idsrc_pkg::C6_HI_ADDR: begin
            rd_data = snap_r;
            rd_err = apb_req.pwrite;
         end
         idsrc_pkg::CORE_SEL_ADDR: begin
            rd_data = {{(idsrc_pkg::DATA_W-idsrc_pkg::CORE_W){1'b0}},
                       core_sel_r};
         end
         default: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // APB answer
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rsp_r <= idsrc_pkg::RSP_RST;
      end else if (acc) begin
         rsp_r.pready <= 1'b1;
         rsp_r.pslverr <= rd_err;
         rsp_r.prdata <= apb_req.pwrite ? idsrc_pkg::RD_ZERO : rd_data;
      end else begin
         rsp_r.pready <= 1'b0;
         rsp_r.pslverr <= 1'b0;
      end
   end

   // High-half snapshot
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         snap_r <= idsrc_pkg::RD_ZERO;
      end else if (acc && snap_load) begin
         snap_r <= snap_nxt;
      end
   end

   // Core select, the only writable field
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         core_sel_r <= idsrc_pkg::CORE_SEL_RST;
      end else if (done && apb_req.pwrite &&
                   apb_req.paddr == idsrc_pkg::CORE_SEL_ADDR) begin
         core_sel_r <= apb_req.pwdata[idsrc_pkg::CORE_W-1:0];
      end
   end

   assign apb_rsp = rsp_r;

   property p_pkg_cause;
      @(posedge clk_sys) disable iff (reset)
      (pkg_c6_val != $past(pkg_c6_val)) |->
         $past(p1_tick) && $past(pkg_state) == idsrc_pkg::ST_C6;
   endproperty
   a_pkg_cause: assert property (p_pkg_cause)
      else $error("package count moved outside C6");

   property p_pkg_runs;
      @(posedge clk_sys) disable iff (reset)
      (p1_tick && pkg_state == idsrc_pkg::ST_C6) [*2] |=>
         pkg_c6_val == $past(pkg_c6_val, 2) + idsrc_pkg::CNT_ONE +
                       idsrc_pkg::CNT_ONE;
   endproperty
   a_pkg_runs: assert property (p_pkg_runs)
      else $error("package count missed a tick in C6");

   property p_no_tick;
      @(posedge clk_sys) disable iff (reset)
      !p1_tick |=> pkg_c6_val == $past(pkg_c6_val) &&
                   c4_val == $past(c4_val) && c6_val == $past(c6_val);
   endproperty
   a_no_tick: assert property (p_no_tick)
      else $error("a counter moved without a P1 tick");

   property p_c4_not_c6;
      @(posedge clk_sys) disable iff (reset)
      pkg_state == idsrc_pkg::ST_C4 |=> pkg_c6_val == $past(pkg_c6_val);
   endproperty
   a_c4_not_c6: assert property (p_c4_not_c6)
      else $error("package C6 count moved on C4 code");

   property p_ro_write;
      @(posedge clk_sys) disable iff (reset)
      (acc && apb_req.pwrite && apb_req.paddr == idsrc_pkg::PKG_LO_ADDR)
         |=> rsp_r.pready && rsp_r.pslverr;
   endproperty
   a_ro_write: assert property (p_ro_write)
      else $error("write to package counter not refused");

   property p_ro_keep;
      @(posedge clk_sys) disable iff (reset)
      (done && apb_req.pwrite && !pkg_c6_inc) |=>
         pkg_c6_val == $past(pkg_c6_val);
   endproperty
   a_ro_keep: assert property (p_ro_keep)
      else $error("bus write changed package counter");

   property p_snap;
      @(posedge clk_sys) disable iff (reset)
      (acc && !apb_req.pwrite && apb_req.paddr == idsrc_pkg::PKG_LO_ADDR)
         |=> {snap_r, rsp_r.prdata} == $past(pkg_c6_val);
   endproperty
   a_snap: assert property (p_snap)
      else $error("package counter read wrong value");

   property p_c4_snap;
      @(posedge clk_sys) disable iff (reset)
      (acc && !apb_req.pwrite && apb_req.paddr == idsrc_pkg::C4_LO_ADDR)
         |=> {snap_r, rsp_r.prdata} == $past(c4_sel);
   endproperty
   a_c4_snap: assert property (p_c4_snap)
      else $error("core C4 counter read wrong value");

   property p_c6_snap;
      @(posedge clk_sys) disable iff (reset)
      (acc && !apb_req.pwrite && apb_req.paddr == idsrc_pkg::C6_LO_ADDR)
         |=> {snap_r, rsp_r.prdata} == $past(c6_sel);
   endproperty
   a_c6_snap: assert property (p_c6_snap)
      else $error("core C6 counter read wrong value");

   property p_hi_read;
      @(posedge clk_sys) disable iff (reset)
      (acc && !apb_req.pwrite && apb_req.paddr == idsrc_pkg::PKG_HI_ADDR)
         |=> rsp_r.prdata == $past(snap_r) && !rsp_r.pslverr;
   endproperty
   a_hi_read: assert property (p_hi_read)
      else $error("package high word not from snapshot");

   property p_c4_hi_ro;
      @(posedge clk_sys) disable iff (reset)
      (acc && apb_req.pwrite && apb_req.paddr == idsrc_pkg::C4_HI_ADDR)
         |=> rsp_r.pready && rsp_r.pslverr;
   endproperty
   a_c4_hi_ro: assert property (p_c4_hi_ro)
      else $error("write to core C4 counter not refused");

   property p_pkg_hold;
      @(posedge clk_sys) disable iff (reset)
      pkg_state != idsrc_pkg::ST_C6 |=> pkg_c6_val == $past(pkg_c6_val);
   endproperty
   a_pkg_hold: assert property (p_pkg_hold)
      else $error("package count moved on another state code");

   // No disable here: this one looks inside reset itself
   property p_rst_clear;
      @(posedge clk_sys)
      reset && $past(reset) |-> pkg_c6_val == idsrc_pkg::CNT_RST &&
         c4_val == {idsrc_pkg::NUM_CORES{idsrc_pkg::CNT_RST}} &&
         c6_val == {idsrc_pkg::NUM_CORES{idsrc_pkg::CNT_RST}} &&
         core_sel_r == idsrc_pkg::CORE_SEL_RST;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("state not cleared by reset");

endmodule

`default_nettype wire

// ---- verif/idsrc_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module idsrc_top_tb;
   logic clk_sys;
   logic reset;
   idsrc_pkg::idsrc_apb_req_t apb_req;
   idsrc_pkg::idsrc_apb_rsp_t apb_rsp;
   logic p1_tick;
   idsrc_pkg::idsrc_state_t pkg_state;
   idsrc_pkg::idsrc_state_t [idsrc_pkg::NUM_CORES-1:0] core_state;
   int error_cnt;
   int tests_run;
   int cyc;
   logic [31:0] rd;
   logic er;
   logic [63:0] v;

   idsrc_top idsrc_top_i (
      .clk_sys(clk_sys),
      .reset(reset),
      .apb_req(apb_req),
      .apb_rsp(apb_rsp),
      .p1_tick(p1_tick),
      .pkg_state(pkg_state),
      .core_state(core_state)
   );

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   task automatic report_and_stop();
      $display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Ceiling well above the few hundred cycles the tests need
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         $display("unexpected at %0t: run hung", $time);
         report_and_stop();
      end
   end

   task automatic chk(input logic [63:0] got, exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got,
                  exp);
      end
   endtask

   // Request held until pready is sampled high
   task automatic apb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                   pwdata: d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      // Only the global ceiling ends a hang
      do begin
         @(posedge clk_sys);
         n++;
      end while (apb_rsp.pready !== 1'b1);
      chk(n, 64'h2, "answer latency");
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   // Lo first, so hi comes from the matching snapshot
   task automatic rd64(input logic [15:0] lo, hi);
      apb(1'b0, lo, 32'h0);
      v[31:0] = rd;
      apb(1'b0, hi, 32'h0);
      v[63:32] = rd;
   endtask

   task automatic ticks(input int n);
      @(posedge clk_sys);
      p1_tick <= 1'b1;
      repeat (n) @(posedge clk_sys);
      p1_tick <= 1'b0;
   endtask

   task automatic t_reset();
      rd64(idsrc_pkg::PKG_LO_ADDR, idsrc_pkg::PKG_HI_ADDR);
      chk(v, 64'h0, "pkg after reset");
      rd64(idsrc_pkg::C4_LO_ADDR, idsrc_pkg::C4_HI_ADDR);
      chk(v, 64'h0, "c4 after reset");
      rd64(idsrc_pkg::C6_LO_ADDR, idsrc_pkg::C6_HI_ADDR);
      chk(v, 64'h0, "c6 after reset");
      apb(1'b0, idsrc_pkg::CORE_SEL_ADDR, 32'h0);
      chk(rd, 64'h0, "core select reset");
      $display("test reset done");
   endtask

   task automatic t_pkg();
      pkg_state <= idsrc_pkg::ST_C4;
      ticks(3);
      rd64(idsrc_pkg::PKG_LO_ADDR, idsrc_pkg::PKG_HI_ADDR);
      chk(v, 64'h0, "pkg counted outside c6");
      pkg_state <= idsrc_pkg::ST_C6;
      ticks(5);
      rd64(idsrc_pkg::PKG_LO_ADDR, idsrc_pkg::PKG_HI_ADDR);
      chk(v, 64'h5, "pkg c6 count");
      // Still in c6 but no tick: must hold
      rd64(idsrc_pkg::PKG_LO_ADDR, idsrc_pkg::PKG_HI_ADDR);
      chk(v, 64'h5, "pkg moved without tick");
      pkg_state <= idsrc_pkg::ST_C4;
      $display("test package done");
   endtask

   task automatic t_core();
      core_state[0] <= idsrc_pkg::ST_C4;
      core_state[1] <= idsrc_pkg::ST_C6;
      ticks(7);
      core_state[0] <= idsrc_pkg::ST_C6;
      core_state[1] <= idsrc_pkg::ST_C4;
      ticks(2);
      core_state <= '0;
      for (int c = 0; c < 2; c++) begin
         apb(1'b1, idsrc_pkg::CORE_SEL_ADDR, 32'(c));
         chk(er, 1'b0, "select write error");
         rd64(idsrc_pkg::C4_LO_ADDR, idsrc_pkg::C4_HI_ADDR);
         chk(v, (c == 0) ? 64'h7 : 64'h2, "core c4 count");
         rd64(idsrc_pkg::C6_LO_ADDR, idsrc_pkg::C6_HI_ADDR);
         chk(v, (c == 0) ? 64'h2 : 64'h7, "core c6 count");
      end
      rd64(idsrc_pkg::PKG_LO_ADDR, idsrc_pkg::PKG_HI_ADDR);
      chk(v, 64'h5, "pkg moved in core test");
      $display("test cores done");
   endtask

   task automatic t_ro();
      apb(1'b1, idsrc_pkg::PKG_LO_ADDR, 32'hffffffff);
      chk(er, 1'b1, "pkg lo write accepted");
      apb(1'b1, idsrc_pkg::C4_HI_ADDR, 32'h12345678);
      chk(er, 1'b1, "c4 hi write accepted");
      rd64(idsrc_pkg::PKG_LO_ADDR, idsrc_pkg::PKG_HI_ADDR);
      chk(v, 64'h5, "pkg changed by write");
      rd64(idsrc_pkg::C4_LO_ADDR, idsrc_pkg::C4_HI_ADDR);
      chk(v, 64'h2, "c4 changed by write");
      apb(1'b0, 16'h0004, 32'h0);
      chk({er, rd}, {1'b1, 32'h0}, "unmapped read");
      apb(1'b1, idsrc_pkg::CORE_SEL_ADDR, 32'h00000003);
      apb(1'b0, idsrc_pkg::CORE_SEL_ADDR, 32'h0);
      chk(rd, 64'h1, "select upper bits");
      $display("test read only done");
   endtask

   // Second reset with counts and select nonzero
   task automatic t_rerun();
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      rd64(idsrc_pkg::PKG_LO_ADDR, idsrc_pkg::PKG_HI_ADDR);
      chk(v, 64'h0, "pkg after second reset");
      rd64(idsrc_pkg::C6_LO_ADDR, idsrc_pkg::C6_HI_ADDR);
      chk(v, 64'h0, "c6 after second reset");
      apb(1'b0, idsrc_pkg::CORE_SEL_ADDR, 32'h0);
      chk(rd, 64'h0, "core select after second reset");
      pkg_state <= idsrc_pkg::ST_C6;
      ticks(3);
      rd64(idsrc_pkg::PKG_LO_ADDR, idsrc_pkg::PKG_HI_ADDR);
      chk(v, 64'h3, "pkg count since second reset");
      $display("test second reset done");
   endtask

   initial begin
      error_cnt = 0;
      tests_run = 0;
      cyc = 0;
      reset = 1'b1;
      apb_req = '0;
      p1_tick = 1'b0;
      pkg_state = 4'h0;
      core_state = '0;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      t_reset();
      t_pkg();
      t_core();
      t_ro();
      t_rerun();
      report_and_stop();
   end
endmodule

`default_nettype wire
